// file: design/flash_pes_map.svh
/*
 * Constants of the flash program/erase and lock-byte block: addresses,
 * field positions, reset values and timing counts.
 * Assumes a 100 MHz core clock and an 18-bit flash byte address.
 */
`ifndef FLASH_PES_MAP_SVH
`define FLASH_PES_MAP_SVH

`define FPE_ADDR_W        18
`define FPE_LOCK_WE_128   18'h1fbfe
`define FPE_LOCK_RD_128   18'h1fbff
`define FPE_LOCK_WE_64    18'h0fffe
`define FPE_LOCK_RD_64    18'h0ffff
`define FPE_SPAD_BASE     18'h20000
`define FPE_SPAD_BIT      17
`define FPE_PAGE_LSB      10
`define FPE_SPAD_PAGE_LSB 7
`define FPE_BLOCK_LSB     14
`define FPE_ERASED        8'hff
`define FPE_LOCK_RESET    8'h00
`define FPE_UNDEF_DATA    8'h00
`define FPE_CLK_MHZ       100
`define FPE_WRITE_TIME_US 40
`define FPE_ERASE_TIME_MS 10
`define FPE_WRITE_CYC     (`FPE_WRITE_TIME_US * `FPE_CLK_MHZ)
`define FPE_ERASE_CYC     (`FPE_ERASE_TIME_MS * 1000 * `FPE_CLK_MHZ)

`endif

// file: design/flash_pes_pkg.sv
/*
 * Types shared by the flash program/erase block, the flash array model and the bench.
 * Assumes flash_pes_map.svh is on the include path.
 */
`include "flash_pes_map.svh"

package flash_pes_pkg;

	typedef enum logic [1:0] {FOP_NONE, FOP_PROGRAM, FOP_ERASE_PAGE, FOP_ERASE_ALL} flash_op_e;
	typedef enum logic [1:0] {JOP_READ, JOP_WRITE, JOP_ERASE} jtag_op_e;
	typedef enum logic [3:0] {
		SEQ_BOOT0, SEQ_BOOT1, SEQ_BOOT2, SEQ_BOOT3,
		SEQ_IDLE, SEQ_JREAD, SEQ_JDATA, SEQ_COMMIT, SEQ_BUSY
	} seq_e;

	typedef struct packed {
		logic       fwe;
		logic       swe;
		logic       see;
		logic       blk;
		logic       scratchpad_access_enable;
		logic [1:0] bank;
	} flash_ctl_s;

	typedef struct packed {
		logic        en;
		logic [15:0] addr;
		logic [7:0]  data;
	} core_wr_s;

	typedef struct packed {
		logic                   req;
		jtag_op_e               op;
		logic [`FPE_ADDR_W-1:0] addr;
		logic [7:0]             wdata;
	} jtag_req_s;

	typedef struct packed {
		logic       ack;
		logic       denied;
		logic [7:0] rdata;
	} jtag_rsp_s;

	typedef struct packed {
		logic                   valid;
		flash_op_e              op;
		logic [`FPE_ADDR_W-1:0] addr;
		logic [31:0]            data;
		logic [3:0]             mask;
	} flash_cmd_s;

endpackage

// file: design/stage_buffer.sv
/*
 * Staging buffer for one flash write block; bytes and valid mask are
 * registers. Assumes clr and we are never high together.
 */
`timescale 1ns/100ps
`default_nettype none
`include "flash_pes_map.svh"

module stage_buffer #(
	parameter int LANES = 4
) (
	// clock and reset
	input  wire logic               clk,
	input  wire logic               rst,
	// control
	input  wire logic               clr,
	input  wire logic               we,
	input  wire logic [1:0]         idx,
	input  wire logic [7:0]         din,
	// contents
	output logic      [LANES*8-1:0] q,
	output logic      [LANES-1:0]   mask
);

	typedef struct packed {
		logic [LANES-1:0][7:0] bytes;
		logic [LANES-1:0]      mask;
	} state_s;

	state_s s_r;
	state_s s_nxt;

	always_comb begin
		s_nxt = s_r;
		for (int i = 0; i < LANES; i++) begin
			if (clr) begin
				s_nxt.bytes[i] = `FPE_ERASED;
				s_nxt.mask[i]  = 1'b0;
			end else if (we && idx == 2'(i)) begin
				s_nxt.bytes[i] = din;
				s_nxt.mask[i]  = 1'b1;
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s_r <= '{bytes: {LANES{`FPE_ERASED}}, mask: '0};
		end else begin
			s_r <= s_nxt;
		end
	end

	assign q    = s_r.bytes;
	assign mask = s_r.mask;

endmodule
`default_nettype wire

// file: design/flash_pes.sv
/*
 * Flash program/erase sequencer with lock-byte security for the debug port.
 * Assumes a flash array that obeys flash_cmd and answers a read the cycle
 * after flash_rd_en is high, and a core that holds off flash fetches while
 * core_stall is high.
 */
`timescale 1ns/100ps
`default_nettype none
`include "flash_pes_map.svh"

module flash_pes #(
	parameter bit BIG_PART     = 1'b1,
	parameter int WRITE_CYCLES = `FPE_WRITE_CYC,
	parameter int ERASE_CYCLES = `FPE_ERASE_CYC
) (
	// clock and reset
	input  wire logic                      core_clk,
	input  wire logic                      rst,
	// core control bits and data-space writes
	input  wire flash_pes_pkg::flash_ctl_s ctl,
	input  wire flash_pes_pkg::core_wr_s   core_wr,
	output flash_pes_pkg::core_wr_s        external_data_ram_wr,
	output logic                           core_stall,
	output logic                           flash_busy_flag,
	// debug port
	input  wire flash_pes_pkg::jtag_req_s  jtag_req,
	output flash_pes_pkg::jtag_rsp_s       jtag_rsp,
	// flash array
	output flash_pes_pkg::flash_cmd_s      flash_cmd,
	output logic                           flash_rd_en,
	output logic      [`FPE_ADDR_W-1:0]    flash_rd_addr,
	input  wire logic [7:0]                flash_rd_data
);

	localparam logic [`FPE_ADDR_W-1:0] LOCK_WE = BIG_PART ? `FPE_LOCK_WE_128 : `FPE_LOCK_WE_64;
	localparam logic [`FPE_ADDR_W-1:0] LOCK_RD = BIG_PART ? `FPE_LOCK_RD_128 : `FPE_LOCK_RD_64;

	typedef struct packed {
		flash_pes_pkg::seq_e       st;
		logic [23:0]               cnt;
		logic                      jpend;
		logic                      busy;
		logic [7:0]                we_lock;
		logic [7:0]                rd_lock;
		logic [`FPE_ADDR_W-1:0]    blk_addr;
		flash_pes_pkg::flash_cmd_s cmd;
		logic                      rd_en;
		logic [`FPE_ADDR_W-1:0]    rd_addr;
		flash_pes_pkg::jtag_rsp_s  rsp;
		flash_pes_pkg::core_wr_s   xw;
	} state_s;

	state_s                 s_r;
	state_s                 s_nxt;
	logic [`FPE_ADDR_W-1:0] caddr;
	logic [`FPE_ADDR_W-1:0] ja;
	logic                   to_flash;
	logic                   last;
	logic                   take_j;
	logic                   is_lock;
	logic                   stg_we;
	logic                   stg_clr;
	logic [31:0]            stg_q;
	logic [3:0]             stg_mask;
	logic [31:0]            jw_data;

	function automatic logic [`FPE_ADDR_W-1:0] map_core(input flash_pes_pkg::flash_ctl_s c, input logic [15:0] a);
		if (c.scratchpad_access_enable) begin
			map_core = `FPE_SPAD_BASE | {10'h000, a[7:0]};
		end else if (a[15]) begin
			map_core = {1'b0, c.bank, a[14:0]};
		end else begin
			map_core = {3'h0, a[14:0]};
		end
	endfunction

	// scratchpad locked only by an all-zero byte, else one bit per 16 kB
	function automatic logic blk_locked(input logic [7:0] lk, input logic [`FPE_ADDR_W-1:0] a);
		if (a[`FPE_SPAD_BIT]) begin
			blk_locked = (lk == 8'h00);
		end else begin
			blk_locked = !lk[a[`FPE_BLOCK_LSB +: 3]];
		end
	endfunction

	function automatic logic [`FPE_ADDR_W-1:0] page_base(input logic [`FPE_ADDR_W-1:0] a);
		page_base = a;
		if (a[`FPE_SPAD_BIT]) begin
			page_base[`FPE_SPAD_PAGE_LSB-1:0] = '0;
		end else begin
			page_base[`FPE_PAGE_LSB-1:0] = '0;
		end
	endfunction

	function automatic logic lock_page(input logic [`FPE_ADDR_W-1:0] a);
		lock_page = a[`FPE_ADDR_W-1:`FPE_PAGE_LSB] == LOCK_WE[`FPE_ADDR_W-1:`FPE_PAGE_LSB];
	endfunction

	// start an operation; lock shadows follow what the array will hold
	function automatic state_s launch(input state_s s, input flash_pes_pkg::flash_op_e op,
		input logic [`FPE_ADDR_W-1:0] a, input logic [31:0] d, input logic [3:0] m, input logic jp);
		state_s r;
		r = s;
		r.cmd.valid = 1'b1;
		r.cmd.op    = op;
		r.cmd.addr  = a;
		r.cmd.data  = d;
		r.cmd.mask  = m;
		r.busy      = 1'b1;
		r.jpend     = jp;
		r.st        = flash_pes_pkg::SEQ_BUSY;
		if (op == flash_pes_pkg::FOP_PROGRAM) begin
			r.cnt = 24'(WRITE_CYCLES - 1);
		end else begin
			r.cnt = 24'(ERASE_CYCLES - 1);
		end
		if (op == flash_pes_pkg::FOP_ERASE_ALL || (op == flash_pes_pkg::FOP_ERASE_PAGE && lock_page(a))) begin
			r.we_lock = `FPE_ERASED;
			r.rd_lock = `FPE_ERASED;
		end
		if (op == flash_pes_pkg::FOP_PROGRAM) begin
			for (int i = 0; i < 4; i++) begin
				if (m[i] && {a[`FPE_ADDR_W-1:2], 2'(i)} == LOCK_WE) begin
					r.we_lock = r.we_lock & d[8*i +: 8];
				end
				if (m[i] && {a[`FPE_ADDR_W-1:2], 2'(i)} == LOCK_RD) begin
					r.rd_lock = r.rd_lock & d[8*i +: 8];
				end
			end
		end
		return r;
	endfunction

	always_comb begin
		caddr    = map_core(ctl, core_wr.addr);
		ja       = jtag_req.addr;
		// debug byte in its lane, other lanes left erased
		jw_data  = 32'hffff_ffff;
		jw_data[8*ja[1:0] +: 8] = jtag_req.wdata;
		is_lock  = (ja == LOCK_WE) || (ja == LOCK_RD);
		to_flash = core_wr.en && ctl.swe;
		if (!ctl.blk) begin
			last = 1'b1;
		end else if (caddr[`FPE_SPAD_BIT]) begin
			last = caddr[0];
		end else begin
			last = caddr[1:0] == 2'b11;
		end
		take_j = jtag_req.req && !s_r.rsp.ack && !to_flash;
		stg_we = s_r.st == flash_pes_pkg::SEQ_IDLE && to_flash && ctl.fwe && !ctl.see;
	end

	assign stg_clr = s_r.st == flash_pes_pkg::SEQ_COMMIT;

	stage_buffer #(
		.LANES (4)
	) u_stage (
		.clk  (core_clk),
		.rst  (rst),
		.clr  (stg_clr),
		.we   (stg_we),
		.idx  (caddr[1:0]),
		.din  (core_wr.data),
		.q    (stg_q),
		.mask (stg_mask)
	);

	always_comb begin
		s_nxt            = s_r;
		s_nxt.cmd.valid  = 1'b0;
		s_nxt.rd_en      = 1'b0;
		s_nxt.rsp.ack    = 1'b0;
		s_nxt.rsp.denied = 1'b0;
		s_nxt.xw.en      = 1'b0;
		if (core_wr.en && !ctl.swe) begin
			s_nxt.xw = core_wr;
		end
		case (s_r.st)
			flash_pes_pkg::SEQ_BOOT0: begin
				s_nxt.rd_en   = 1'b1;
				s_nxt.rd_addr = LOCK_WE;
				s_nxt.st      = flash_pes_pkg::SEQ_BOOT1;
			end
			flash_pes_pkg::SEQ_BOOT1: begin
				s_nxt.rd_en   = 1'b1;
				s_nxt.rd_addr = LOCK_RD;
				s_nxt.st      = flash_pes_pkg::SEQ_BOOT2;
			end
			flash_pes_pkg::SEQ_BOOT2: begin
				s_nxt.we_lock = flash_rd_data;
				s_nxt.st      = flash_pes_pkg::SEQ_BOOT3;
			end
			flash_pes_pkg::SEQ_BOOT3: begin
				s_nxt.rd_lock = flash_rd_data;
				s_nxt.st      = flash_pes_pkg::SEQ_IDLE;
			end
			flash_pes_pkg::SEQ_IDLE: begin
				if (to_flash) begin
					if (ctl.fwe && ctl.see) begin
						if (!lock_page(caddr)) begin
							s_nxt = launch(s_nxt, flash_pes_pkg::FOP_ERASE_PAGE, page_base(caddr),
								32'h0000_0000, 4'h0, 1'b0);
						end
					end else if (ctl.fwe) begin
						s_nxt.blk_addr = {caddr[`FPE_ADDR_W-1:2], 2'b00};
						if (last) begin
							s_nxt.st = flash_pes_pkg::SEQ_COMMIT;
						end
					end
				end else if (take_j) begin
					case (jtag_req.op)
						flash_pes_pkg::JOP_READ: begin
							if (ja == LOCK_WE) begin
								s_nxt.rsp.ack   = 1'b1;
								s_nxt.rsp.rdata = s_r.we_lock;
							end else if (ja == LOCK_RD) begin
								s_nxt.rsp.ack   = 1'b1;
								s_nxt.rsp.rdata = s_r.rd_lock;
							end else if (blk_locked(s_r.rd_lock, ja)) begin
								s_nxt.rsp.ack    = 1'b1;
								s_nxt.rsp.denied = 1'b1;
								s_nxt.rsp.rdata  = `FPE_UNDEF_DATA;
							end else begin
								s_nxt.rd_en   = 1'b1;
								s_nxt.rd_addr = ja;
								s_nxt.st      = flash_pes_pkg::SEQ_JREAD;
							end
						end
						flash_pes_pkg::JOP_WRITE: begin
							if (is_lock || !blk_locked(s_r.we_lock, ja)) begin
								s_nxt = launch(s_nxt, flash_pes_pkg::FOP_PROGRAM, {ja[`FPE_ADDR_W-1:2], 2'b00},
									jw_data, 4'h1 << ja[1:0], 1'b1);
							end else begin
								s_nxt.rsp.ack    = 1'b1;
								s_nxt.rsp.denied = 1'b1;
							end
						end
						flash_pes_pkg::JOP_ERASE: begin
							if (is_lock) begin
								s_nxt = launch(s_nxt, flash_pes_pkg::FOP_ERASE_ALL, '0, 32'h0000_0000,
									4'h0, 1'b1);
							end else if (blk_locked(s_r.we_lock, ja)) begin
								s_nxt.rsp.ack    = 1'b1;
								s_nxt.rsp.denied = 1'b1;
							end else begin
								s_nxt = launch(s_nxt, flash_pes_pkg::FOP_ERASE_PAGE, page_base(ja),
									32'h0000_0000, 4'h0, 1'b1);
							end
						end
						default: begin
							s_nxt.rsp.ack    = 1'b1;
							s_nxt.rsp.denied = 1'b1;
						end
					endcase
				end
			end
			flash_pes_pkg::SEQ_JREAD: begin
				s_nxt.st = flash_pes_pkg::SEQ_JDATA;
			end
			flash_pes_pkg::SEQ_JDATA: begin
				s_nxt.rsp.ack   = 1'b1;
				s_nxt.rsp.rdata = flash_rd_data;
				s_nxt.st        = flash_pes_pkg::SEQ_IDLE;
			end
			flash_pes_pkg::SEQ_COMMIT: begin
				s_nxt = launch(s_nxt, flash_pes_pkg::FOP_PROGRAM, s_r.blk_addr, stg_q, stg_mask,
					1'b0);
			end
			flash_pes_pkg::SEQ_BUSY: begin
				if (s_r.cnt == 24'h00_0000) begin
					s_nxt.busy    = 1'b0;
					s_nxt.st      = flash_pes_pkg::SEQ_IDLE;
					s_nxt.rsp.ack = s_r.jpend;
					s_nxt.jpend   = 1'b0;
				end else begin
					s_nxt.cnt = s_r.cnt - 24'h00_0001;
				end
			end
			default: begin
				s_nxt.st = flash_pes_pkg::SEQ_IDLE;
			end
		endcase
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign external_data_ram_wr         = s_r.xw;
	assign core_stall      = s_r.busy;
	assign flash_busy_flag = s_r.busy;
	assign jtag_rsp        = s_r.rsp;
	assign flash_cmd       = s_r.cmd;
	assign flash_rd_en     = s_r.rd_en;
	assign flash_rd_addr   = s_r.rd_addr;

	// checks
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);

	logic idle_w;
	logic idle_prog;
	logic jt_idle;
	assign idle_w    = s_r.st == flash_pes_pkg::SEQ_IDLE && to_flash;
	assign idle_prog = idle_w && ctl.fwe && !ctl.see;
	assign jt_idle   = s_r.st == flash_pes_pkg::SEQ_IDLE && take_j;

	sequence s_commit;
		(s_r.st == flash_pes_pkg::SEQ_COMMIT) ##1 (s_r.cmd.valid && s_r.cmd.op == flash_pes_pkg::FOP_PROGRAM);
	endsequence

	a_byte_launch: assert property (idle_prog && !ctl.blk |=> s_commit)
		else $error("byte write did not launch a program");
	a_block_hold: assert property (idle_prog && ctl.blk && !caddr[17] && caddr[1:0] != 2'b11
		|=> s_r.st == flash_pes_pkg::SEQ_IDLE && !s_r.cmd.valid)
		else $error("block program launched before last byte");
	a_block_four: assert property (idle_prog && ctl.blk && !caddr[17] && caddr[1:0] == 2'b11 |=> s_commit)
		else $error("code block did not commit");
	a_spad_pair: assert property (idle_prog && ctl.blk && caddr[17] && caddr[0] |=> s_commit)
		else $error("scratchpad block did not commit");
	a_erase_page: assert property (idle_w && ctl.fwe && ctl.see && !lock_page(caddr)
		|=> s_r.cmd.valid && s_r.cmd.op == flash_pes_pkg::FOP_ERASE_PAGE && s_r.busy)
		else $error("enabled erase not started");
	a_core_refused: assert property (idle_w && !ctl.fwe |=> !s_r.cmd.valid && s_r.st == flash_pes_pkg::SEQ_IDLE)
		else $error("write without enable reached flash");
	a_lock_noerase: assert property (idle_w && ctl.fwe && ctl.see && lock_page(caddr) |=> !s_r.cmd.valid)
		else $error("software erased the lock page");
	a_prog_time: assert property (s_r.cmd.valid && s_r.cmd.op == flash_pes_pkg::FOP_PROGRAM
		|-> s_r.cnt == 24'(WRITE_CYCLES - 1))
		else $error("program time differs");
	a_busy_end: assert property ($fell(s_r.busy) |-> $past(s_r.cnt) == 24'h00_0000 && !core_stall)
		else $error("busy dropped early");
	a_lock_read: assert property (jt_idle && jtag_req.op == flash_pes_pkg::JOP_READ && ja == LOCK_WE
		|=> s_r.rsp.ack && !s_r.rsp.denied && s_r.rsp.rdata == $past(s_r.we_lock))
		else $error("lock byte read wrong");
	a_read_deny: assert property (jt_idle && jtag_req.op == flash_pes_pkg::JOP_READ && !is_lock
		&& blk_locked(s_r.rd_lock, ja) |=> s_r.rsp.ack && s_r.rsp.denied && s_r.st == flash_pes_pkg::SEQ_IDLE)
		else $error("locked read not refused");
	a_write_deny: assert property (jt_idle && jtag_req.op != flash_pes_pkg::JOP_READ && !is_lock
		&& blk_locked(s_r.we_lock, ja) |=> s_r.rsp.denied && !s_r.cmd.valid)
		else $error("locked write or erase not refused");
	a_spad_open: assert property (jt_idle && jtag_req.op == flash_pes_pkg::JOP_READ && ja[17]
		&& s_r.rd_lock != 8'h00 |=> s_r.st == flash_pes_pkg::SEQ_JREAD ##1 s_r.st == flash_pes_pkg::SEQ_JDATA)
		else $error("scratchpad read refused");
	a_full_erase: assert property (jt_idle && jtag_req.op == flash_pes_pkg::JOP_ERASE && is_lock
		|=> s_r.cmd.op == flash_pes_pkg::FOP_ERASE_ALL && s_r.cmd.valid && s_r.we_lock == `FPE_ERASED)
		else $error("full erase not started");
	a_page_unlock: assert property (jt_idle && jtag_req.op == flash_pes_pkg::JOP_ERASE && !is_lock && lock_page(ja)
		&& !blk_locked(s_r.we_lock, ja) |=> s_r.we_lock == `FPE_ERASED && s_r.rd_lock == `FPE_ERASED)
		else $error("lock page erase kept locks");
	a_lock_clears: assert property ($past(s_r.st) == flash_pes_pkg::SEQ_IDLE
		&& !(s_r.cmd.valid && s_r.cmd.op != flash_pes_pkg::FOP_PROGRAM) |-> (s_r.we_lock & ~$past(s_r.we_lock)) == 8'h00)
		else $error("program set a lock bit");
	a_external_data_ram_steer: assert property (core_wr.en && !ctl.swe |=> s_r.xw.en && s_r.xw.addr == $past(core_wr.addr))
		else $error("data write not steered to ram");

endmodule
`default_nettype wire

// file: bench/flash_array_model.sv
/*
 * Behavioural flash array on the far side of flash_pes: applies program
 * and erase commands to a sparse byte image and answers reads.
 * Assumes reads are sampled the cycle after flash_rd_en; erased bytes are 0xff.
 */
`timescale 1ns/100ps
`default_nettype none
`include "flash_pes_map.svh"

module flash_array_model (
	// clock
	input  wire logic                      core_clk,
	// commands and reads
	input  wire flash_pes_pkg::flash_cmd_s flash_cmd,
	input  wire logic                      flash_rd_en,
	input  wire logic [`FPE_ADDR_W-1:0]    flash_rd_addr,
	output logic      [7:0]                flash_rd_data
);
	logic [7:0] mem [int];

	function automatic logic [7:0] peek(input int a);
		return mem.exists(a) ? mem[a] : `FPE_ERASED;
	endfunction

	task automatic preload(input int a, input logic [7:0] d);
		mem[a] = d;
	endtask

	initial flash_rd_data = 8'h5a;

	always @(posedge core_clk) begin
		int base;
		int span;
		// read data lives one cycle, then is scrambled
		if (flash_rd_en)
			flash_rd_data <= peek(int'(flash_rd_addr));
		else
			flash_rd_data <= ~flash_rd_data;
		if (flash_cmd.valid === 1'b1) begin
			base = int'(flash_cmd.addr);
			case (flash_cmd.op)
				flash_pes_pkg::FOP_PROGRAM:
					for (int i = 0; i < 4; i++)
						if (flash_cmd.mask[i])
							mem[base + i] = peek(base + i) & flash_cmd.data[8*i +: 8];
				flash_pes_pkg::FOP_ERASE_PAGE: begin
					span = flash_cmd.addr[`FPE_SPAD_BIT] ? 128 : 1024;
					for (int i = 0; i < span; i++)
						mem.delete(base + i);
				end
				flash_pes_pkg::FOP_ERASE_ALL: mem.delete();
				default: ;
			endcase
		end
	end
endmodule
`default_nettype wire

// file: bench/flash_pes_tb.sv
/*
 * Self-checking bench of flash_pes: core writes and debug requests against
 * a byte image kept by the bench; commands, busy time and read data compared.
 * Assumes flash_array_model as the array and short program/erase counts.
 */
`timescale 1ns/100ps
`default_nettype none
`include "flash_pes_map.svh"

`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin mismatches++; \
	$display("ERROR %s expected %0h seen %0h", nm, e, g); end end

module flash_pes_tb;
	localparam int WR_N  = 8;
	localparam int ER_N  = 16;
	localparam int LIMIT = 3000;
	localparam int LK_WE = `FPE_LOCK_WE_128;
	localparam int LK_RD = `FPE_LOCK_RD_128;

	logic                      core_clk;
	logic                      rst;
	flash_pes_pkg::flash_ctl_s ctl;
	flash_pes_pkg::core_wr_s   core_wr;
	flash_pes_pkg::core_wr_s   external_data_ram_wr;
	flash_pes_pkg::core_wr_s   last_external_data_ram;
	logic                      core_stall;
	logic                      flash_busy_flag;
	flash_pes_pkg::jtag_req_s  jtag_req;
	flash_pes_pkg::jtag_rsp_s  jtag_rsp;
	flash_pes_pkg::flash_cmd_s flash_cmd;
	flash_pes_pkg::flash_cmd_s last_cmd;
	logic                      flash_rd_en;
	logic [`FPE_ADDR_W-1:0]    flash_rd_addr;
	logic [7:0]                flash_rd_data;
	logic [7:0]                emem [int];
	logic [31:0]               edata;
	logic [3:0]                emask;
	int                        mismatches = 0, n_tests = 0, cyc = 0, last_en = 0, cmd_dt = 0;
	int                        busy_run = 0, busy_len = 0, n_cmd = 0, n_external_data_ram = 0, e_cmd = 0;
	int                        seed = 32'h3bb6f2b5;

	flash_pes #(.BIG_PART(1'b1), .WRITE_CYCLES(WR_N), .ERASE_CYCLES(ER_N)) flash_pes_inst (
		.core_clk(core_clk), .rst(rst), .ctl(ctl), .core_wr(core_wr), .external_data_ram_wr(external_data_ram_wr),
		.core_stall(core_stall), .flash_busy_flag(flash_busy_flag), .jtag_req(jtag_req),
		.jtag_rsp(jtag_rsp), .flash_cmd(flash_cmd), .flash_rd_en(flash_rd_en),
		.flash_rd_addr(flash_rd_addr), .flash_rd_data(flash_rd_data));

	flash_array_model flash_array_model_inst (
		.core_clk(core_clk), .flash_cmd(flash_cmd), .flash_rd_en(flash_rd_en),
		.flash_rd_addr(flash_rd_addr), .flash_rd_data(flash_rd_data));

	initial core_clk = 1'b0;
	always #5 core_clk = ~core_clk;

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// watches commands, busy length and ram writes
	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		if (cyc == LIMIT) begin
			mismatches++;
			report_and_stop();
		end
		if (!rst)
			`CHK("stall", flash_busy_flag, core_stall)
		if (core_wr.en === 1'b1)
			last_en <= cyc;
		if (flash_cmd.valid === 1'b1) begin
			last_cmd <= flash_cmd;
			cmd_dt <= cyc - last_en;
			n_cmd <= n_cmd + 1;
		end
		if (flash_busy_flag === 1'b1)
			busy_run <= busy_run + 1;
		else if (busy_run != 0) begin
			busy_len <= busy_run;
			busy_run <= 0;
		end
		if (external_data_ram_wr.en === 1'b1) begin
			last_external_data_ram <= external_data_ram_wr;
			n_external_data_ram <= n_external_data_ram + 1;
		end
	end

	function automatic logic [7:0] epeek(input int a);
		return emem.exists(a) ? emem[a] : 8'hff;
	endfunction

	function automatic logic [7:0] rnd8();
		int r;
		r = $random(seed);
		return r[7:0];
	endfunction

	task automatic clr_blk();
		edata = '1;
		emask = '0;
	endtask

	task automatic stage(input int a, input logic [7:0] d);
		edata[8*a[1:0] +: 8] = d;
		emask[a[1:0]] = 1'b1;
		emem[a] = epeek(a) & d;
	endtask

	task automatic eerase(input int b, input int span);
		for (int i = 0; i < span; i++)
			emem.delete(b + i);
	endtask

	task automatic do_reset(input int n);
		rst <= 1'b1;
		repeat (n) @(posedge core_clk);
		rst <= 1'b0;
		repeat (8) @(posedge core_clk);
	endtask

	task automatic set_ctl(input logic fwe, swe, see, blk, scratchpad_access_enable, input logic [1:0] bank);
		@(posedge core_clk);
		ctl <= '{fwe: fwe, swe: swe, see: see, blk: blk, scratchpad_access_enable: scratchpad_access_enable, bank: bank};
	endtask

	task automatic core_write(input logic [15:0] a, input logic [7:0] d);
		@(posedge core_clk);
		core_wr <= '{en: 1'b1, addr: a, data: d};
		@(posedge core_clk);
		core_wr.en <= 1'b0;
	endtask

	task automatic jtag(input flash_pes_pkg::jtag_op_e op, input int a, input logic [7:0] wd,
			input logic dn, input int rd);
		int i;
		@(posedge core_clk);
		jtag_req <= '{req: 1'b1, op: op, addr: a[17:0], wdata: wd};
		i = 0;
		do begin
			@(posedge core_clk);
			i++;
		end while (jtag_rsp.ack !== 1'b1 && i < 100);
		jtag_req.req <= 1'b0;
		`CHK("debug denied", dn, jtag_rsp.denied)
		if (rd >= 0)
			`CHK("debug data", rd[7:0], jtag_rsp.rdata)
	endtask

	// waits for idle, then compares the last command with the expectation
	task automatic chk_cmd(input string nm, input flash_pes_pkg::flash_op_e op, input int a, input int dt);
		int i;
		repeat (4) @(posedge core_clk);
		for (i = 0; i < 100 && flash_busy_flag !== 1'b0; i++)
			@(posedge core_clk);
		repeat (2) @(posedge core_clk);
		e_cmd += (op == flash_pes_pkg::FOP_NONE) ? 0 : 1;
		`CHK({nm, " count"}, e_cmd, n_cmd)
		if (op != flash_pes_pkg::FOP_NONE) begin
			`CHK({nm, " op"}, op, last_cmd.op)
			`CHK({nm, " busy"}, (op == flash_pes_pkg::FOP_PROGRAM ? WR_N : ER_N), busy_len)
		end
		if (a >= 0)
			`CHK({nm, " addr"}, a[17:0], last_cmd.addr)
		if (dt > 0)
			`CHK({nm, " delay"}, dt, cmd_dt)
		if (op == flash_pes_pkg::FOP_PROGRAM) begin
			`CHK({nm, " data"}, edata, last_cmd.data)
			`CHK({nm, " mask"}, emask, last_cmd.mask)
		end
		$display("test %s done", nm);
	endtask

	initial begin
		logic [7:0] d;
		int i;
		rst = 1'b1;
		ctl = '0;
		core_wr = '0;
		jtag_req = '0;
		flash_array_model_inst.preload(LK_WE, 8'hfe);
		flash_array_model_inst.preload(LK_RD, 8'hfd);
		emem[LK_WE] = 8'hfe;
		emem[LK_RD] = 8'hfd;
		do_reset(20);
		d = rnd8();
		set_ctl(1, 0, 1, 0, 0, 0);
		core_write(16'h0042, d);
		repeat (2) @(posedge core_clk);
		`CHK("ram addr", 16'h0042, last_external_data_ram.addr)
		`CHK("ram data", d, last_external_data_ram.data)
		chk_cmd("ram path", flash_pes_pkg::FOP_NONE, -1, 0);
		set_ctl(0, 1, 1, 0, 0, 0);
		core_write(16'h0010, d);
		chk_cmd("no enable", flash_pes_pkg::FOP_NONE, -1, 0);
		`CHK("ram count", 1, n_external_data_ram)
		set_ctl(1, 1, 0, 0, 0, 0);
		for (i = 0; i < 2; i++) begin
			d = rnd8();
			clr_blk();
			stage(32'h123, d);
			core_write(16'h0123, d);
			chk_cmd("byte program", flash_pes_pkg::FOP_PROGRAM, 32'h120, 2);
		end
		jtag(flash_pes_pkg::JOP_READ, 32'h123, 8'h00, 1'b0, epeek(32'h123));
		set_ctl(1, 1, 0, 1, 0, 0);
		clr_blk();
		for (i = 0; i < 4; i++) begin
			d = rnd8();
			stage(32'h200 + i, d);
			core_write(16'h0200 + i[15:0], d);
		end
		chk_cmd("code block", flash_pes_pkg::FOP_PROGRAM, 32'h200, 2);
		set_ctl(1, 1, 0, 1, 1, 0);
		clr_blk();
		for (i = 0; i < 2; i++) begin
			d = rnd8();
			stage(32'h20010 + i, d);
			core_write(16'h0010 + i[15:0], d);
		end
		chk_cmd("pad block", flash_pes_pkg::FOP_PROGRAM, 32'h20010, 2);
		set_ctl(1, 1, 1, 0, 1, 0);
		core_write(16'h0090, 8'h00);
		eerase(32'h20080, 128);
		chk_cmd("pad erase", flash_pes_pkg::FOP_ERASE_PAGE, 32'h20080, 1);
		jtag(flash_pes_pkg::JOP_READ, 32'h20011, 8'h00, 1'b0, epeek(32'h20011));
		set_ctl(1, 1, 1, 0, 0, 0);
		core_write(16'h0333, 8'h00);
		eerase(0, 1024);
		chk_cmd("page erase", flash_pes_pkg::FOP_ERASE_PAGE, 0, 1);
		jtag(flash_pes_pkg::JOP_READ, 32'h123, 8'h00, 1'b0, 8'hff);
		set_ctl(1, 1, 1, 0, 0, 3);
		core_write(16'hf900, 8'h00);
		chk_cmd("lock page", flash_pes_pkg::FOP_NONE, -1, 0);
		set_ctl(0, 0, 0, 0, 0, 0);
		jtag(flash_pes_pkg::JOP_READ, 32'h4100, 8'h00, 1'b1, 0);
		jtag(flash_pes_pkg::JOP_WRITE, 32'h0100, 8'h00, 1'b1, -1);
		chk_cmd("locked write", flash_pes_pkg::FOP_NONE, -1, 0);
		jtag(flash_pes_pkg::JOP_READ, LK_RD, 8'h00, 1'b0, 8'hfd);
		d = rnd8();
		clr_blk();
		stage(32'h8001, d);
		jtag(flash_pes_pkg::JOP_WRITE, 32'h8001, d, 1'b0, -1);
		chk_cmd("debug write", flash_pes_pkg::FOP_PROGRAM, 32'h8000, 0);
		eerase(32'h1f800, 1024);
		jtag(flash_pes_pkg::JOP_ERASE, 32'h1f800, 8'h00, 1'b0, -1);
		chk_cmd("lock erase", flash_pes_pkg::FOP_ERASE_PAGE, 32'h1f800, 0);
		jtag(flash_pes_pkg::JOP_READ, 32'h4100, 8'h00, 1'b0, epeek(32'h4100));
		clr_blk();
		stage(LK_WE, 8'h7f);
		jtag(flash_pes_pkg::JOP_WRITE, LK_WE, 8'h7f, 1'b0, -1);
		chk_cmd("lock write", flash_pes_pkg::FOP_PROGRAM, LK_WE & ~3, 0);
		do_reset(3);
		jtag(flash_pes_pkg::JOP_ERASE, 32'h1f800, 8'h00, 1'b1, -1);
		jtag(flash_pes_pkg::JOP_ERASE, LK_RD, 8'h00, 1'b0, -1);
		emem.delete();
		chk_cmd("full erase", flash_pes_pkg::FOP_ERASE_ALL, -1, 0);
		jtag(flash_pes_pkg::JOP_READ, 32'h4100, 8'h00, 1'b0, 8'hff);
		report_and_stop();
	end
endmodule
`default_nettype wire
